// file: logic/ebs_ack_sync.sv
// transfer acknowledge conditioning, direct or through a two stage synchroniser
`timescale 1ns/1ps
module ebs_ack_sync (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic transfer_ack_n,
    input  wire logic ack_sync_select,
    output logic      ack_seen
);
    logic meta_q;
    logic sync_q;

    // ------------------------------------------------------------
    // synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= ebs_pkg::PIN_IDLE_N;
            sync_q <= ebs_pkg::PIN_IDLE_N;
        end else begin
            meta_q <= transfer_ack_n;
            sync_q <= meta_q;
        end
    end

    // select 1: asynchronous acknowledge, 0: sampled directly
    assign ack_seen = ack_sync_select ? !sync_q : !transfer_ack_n;
endmodule

// file: logic/ebs_pkg.sv
// shared types and constants for the external bus strobe and request block
package ebs_pkg;
    // ------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------
    localparam int   WAIT_W         = 4;
    localparam logic PIN_IDLE_N     = 1'b1;
    localparam logic OE_DRIVE_N     = 1'b0;
    localparam logic OE_RELEASE_N   = 1'b1;
    localparam logic [WAIT_W-1:0] WAIT_ZERO = 4'h0;
    localparam logic [WAIT_W-1:0] WAIT_ONE  = 4'h1;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ACCESS,
        ST_FINISH
    } ebs_state_t;

    // bus control and operating mode settings held by the core
    typedef struct packed {
        logic [WAIT_W-1:0] wait_states;
        logic              request_hold_bit;
        logic              ack_sync_select;
    } ebs_cfg_t;

    // access request from the core
    typedef struct packed {
        logic valid;
        logic write;
        logic external;
        logic dram;
    } ebs_req_t;
endpackage

// file: logic/ebs_port.sv
// external bus read/write strobes, acknowledge wait states and bus request
`timescale 1ns/1ps
module ebs_port #(
    parameter int WAIT_W = ebs_pkg::WAIT_W
) (
    input  wire logic             MCLK,
    input  wire logic             RST_N,
    input  wire ebs_pkg::ebs_cfg_t CFG,
    input  wire ebs_pkg::ebs_req_t REQ,
    output logic                  REQ_READY,
    output logic                  DONE,
    input  wire logic             LOW_POWER,
    input  wire logic             BUS_GRANT_N,
    input  wire logic             TRANSFER_ACK_N,
    output logic                  READ_N_O,
    output logic                  READ_OE_N,
    output logic                  WRITE_N_O,
    output logic                  WRITE_OE_N,
    output logic                  BUS_REQUEST_N,
    output logic                  BUS_BUSY_N_O,
    output logic                  BUS_BUSY_OE_N,
    output logic                  IS_MASTER
);
    // the counter and the configuration field must share one width
    if (WAIT_W != ebs_pkg::WAIT_W) begin : g_width_check
        $error("ebs_port: WAIT_W must match the configuration field width");
    end

    ebs_pkg::ebs_state_t st_q;
    logic [WAIT_W-1:0]   cnt_q;
    logic                wr_q;
    logic                ack_used_q;
    logic                master_q;
    logic                req_q;
    logic                ack_seen;
    logic                ack_ok;
    logic                start;
    logic                need;

    // ------------------------------------------------------------
    // acknowledge input
    // ------------------------------------------------------------
    ebs_ack_sync u_ack (
        .clk             (MCLK),
        .rst_n           (RST_N),
        .transfer_ack_n  (TRANSFER_ACK_N),
        .ack_sync_select (CFG.ack_sync_select),
        .ack_seen        (ack_seen)
    );

    // ack only counts during an access that may be extended
    assign ack_ok = !ack_used_q || ack_seen;

    // ------------------------------------------------------------
    // access sequencing
    // ------------------------------------------------------------
    assign REQ_READY = (st_q == ebs_pkg::ST_IDLE) && master_q && !LOW_POWER;
    assign start     = REQ.valid && REQ.external && REQ_READY;

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            st_q <= ebs_pkg::ST_IDLE;
        end else begin
            case (st_q)
                ebs_pkg::ST_IDLE: begin
                    if (start) begin
                        st_q <= ebs_pkg::ST_ACCESS;
                    end
                end
                ebs_pkg::ST_ACCESS: begin
                    if (cnt_q == ebs_pkg::WAIT_ZERO && ack_ok) begin
                        st_q <= ebs_pkg::ST_FINISH;
                    end
                end
                ebs_pkg::ST_FINISH: begin
                    st_q <= ebs_pkg::ST_IDLE;
                end
                default: begin
                    st_q <= ebs_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // wait-state counter
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            cnt_q <= ebs_pkg::WAIT_ZERO;
        end else if (start) begin
            cnt_q <= CFG.wait_states;
        end else if (st_q == ebs_pkg::ST_ACCESS && cnt_q != ebs_pkg::WAIT_ZERO) begin
            cnt_q <= cnt_q - ebs_pkg::WAIT_ONE;
        end
    end

    // access attributes captured at start
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            wr_q       <= 1'b0;
            ack_used_q <= 1'b0;
        end else if (start) begin
            wr_q       <= REQ.write;
            ack_used_q <= (CFG.wait_states != ebs_pkg::WAIT_ZERO) && !REQ.dram;
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            DONE <= 1'b0;
        end else begin
            DONE <= (st_q == ebs_pkg::ST_FINISH);
        end
    end

    // ------------------------------------------------------------
    // strobes
    // ------------------------------------------------------------
    assign READ_N_O   = !(st_q != ebs_pkg::ST_IDLE && !wr_q);
    assign WRITE_N_O  = !(st_q != ebs_pkg::ST_IDLE && wr_q);
    assign READ_OE_N  = master_q ? ebs_pkg::OE_DRIVE_N : ebs_pkg::OE_RELEASE_N;
    assign WRITE_OE_N = master_q ? ebs_pkg::OE_DRIVE_N : ebs_pkg::OE_RELEASE_N;

    // ------------------------------------------------------------
    // arbitration
    // ------------------------------------------------------------
    // mastership kept while granted; released only between accesses
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            master_q <= 1'b0;
        end else if (!BUS_GRANT_N) begin
            master_q <= 1'b1;
        end else if (st_q == ebs_pkg::ST_IDLE && !start) begin
            // never drop mastership on the edge that starts an access
            master_q <= 1'b0;
        end
    end

    assign BUS_BUSY_N_O  = !master_q;
    assign BUS_BUSY_OE_N = master_q ? ebs_pkg::OE_DRIVE_N : ebs_pkg::OE_RELEASE_N;
    assign IS_MASTER     = master_q;

    assign need = (REQ.valid && REQ.external) || (st_q != ebs_pkg::ST_IDLE);

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            req_q <= 1'b0;
        end else if (LOW_POWER) begin
            req_q <= CFG.request_hold_bit ? req_q : 1'b0;
        end else begin
            req_q <= need || CFG.request_hold_bit;
        end
    end

    // request follows the registered need or the hold bit, master or not; low power clears it unless the hold bit keeps it
    assign BUS_REQUEST_N = !req_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_rd_release;
        @(posedge MCLK) disable iff (!RST_N) !master_q |-> READ_OE_N && READ_N_O;
    endproperty
    a_rd_release: assert property (p_rd_release) else $error("read strobe driven while slave");

    property p_wr_strobe;
        @(posedge MCLK) disable iff (!RST_N) (start && REQ.write) |=> !WRITE_N_O && READ_N_O && !WRITE_OE_N;
    endproperty
    a_wr_strobe: assert property (p_wr_strobe) else $error("write strobe not asserted");

    property p_ack_wait;
        @(posedge MCLK) disable iff (!RST_N)
            (st_q == ebs_pkg::ST_ACCESS && ack_used_q && !ack_seen) |=> st_q == ebs_pkg::ST_ACCESS;
    endproperty
    a_ack_wait: assert property (p_ack_wait) else $error("cycle ended without acknowledge");

    property p_ack_end;
        @(posedge MCLK) disable iff (!RST_N)
            (st_q == ebs_pkg::ST_ACCESS && cnt_q == ebs_pkg::WAIT_ZERO && ack_seen)
            |=> st_q == ebs_pkg::ST_FINISH ##1 (st_q == ebs_pkg::ST_IDLE && DONE);
    endproperty
    a_ack_end: assert property (p_ack_end) else $error("cycle not completed after acknowledge");

    property p_min_wait;
        @(posedge MCLK) disable iff (!RST_N)
            (st_q == ebs_pkg::ST_ACCESS && cnt_q != ebs_pkg::WAIT_ZERO) |=> st_q == ebs_pkg::ST_ACCESS;
    endproperty
    a_min_wait: assert property (p_min_wait) else $error("cycle shorter than programmed wait");

    property p_zero_wait;
        @(posedge MCLK) disable iff (!RST_N)
            (start && CFG.wait_states == ebs_pkg::WAIT_ZERO) |=> ##1 st_q == ebs_pkg::ST_FINISH;
    endproperty
    a_zero_wait: assert property (p_zero_wait) else $error("zero wait access extended");

    property p_load;
        @(posedge MCLK) disable iff (!RST_N) start |=> cnt_q == $past(CFG.wait_states);
    endproperty
    a_load: assert property (p_load) else $error("wait counter not loaded");

    property p_req_need;
        @(posedge MCLK) disable iff (!RST_N) start |=> !BUS_REQUEST_N;
    endproperty
    a_req_need: assert property (p_req_need) else $error("bus request missing during access");

    property p_req_idle;
        @(posedge MCLK) disable iff (!RST_N)
            (!LOW_POWER && !CFG.request_hold_bit && (!REQ.valid || !REQ.external) && st_q == ebs_pkg::ST_IDLE)
            |=> BUS_REQUEST_N;
    endproperty
    a_req_idle: assert property (p_req_idle) else $error("bus request without need");

    property p_hold;
        @(posedge MCLK) disable iff (!RST_N) (!LOW_POWER && CFG.request_hold_bit) |=> !BUS_REQUEST_N;
    endproperty
    a_hold: assert property (p_hold) else $error("hold bit did not keep request");

    property p_low_power;
        @(posedge MCLK) disable iff (!RST_N)
            LOW_POWER |=> ($past(CFG.request_hold_bit) ? BUS_REQUEST_N == $past(BUS_REQUEST_N)
                                                       : BUS_REQUEST_N);
    endproperty
    a_low_power: assert property (p_low_power) else $error("request wrong in stop or wait");

    property p_park;
        @(posedge MCLK) disable iff (!RST_N) (master_q && !BUS_GRANT_N) |=> master_q && !BUS_BUSY_N_O;
    endproperty
    a_park: assert property (p_park) else $error("mastership lost while granted");

    c_read:  cover property (@(posedge MCLK) disable iff (!RST_N) start && !REQ.write);
    c_write: cover property (@(posedge MCLK) disable iff (!RST_N) start && REQ.write);
    c_ext:   cover property (@(posedge MCLK) disable iff (!RST_N)
                 st_q == ebs_pkg::ST_ACCESS && cnt_q == ebs_pkg::WAIT_ZERO && !ack_ok);
    c_park:  cover property (@(posedge MCLK) disable iff (!RST_N) master_q && BUS_REQUEST_N);
endmodule

// file: verif/ebs_far_side.sv
// far side model: bus arbiter and external memory acknowledge responder
`timescale 1ns/1ps
module ebs_far_side (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       rd_pin_n,
    input  wire logic       wr_pin_n,
    input  wire logic       bus_request_n,
    input  wire logic [2:0] ack_delay,
    output logic            bus_grant_n,
    output logic            transfer_ack_n
);
    logic [4:0] cnt_q;
    // grant follows the request one cycle later
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            bus_grant_n <= 1'b1;
        else
            bus_grant_n <= bus_request_n;
    end
    // ack held off at cycle start, given after the delay, removed between cycles
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 5'h00;
            transfer_ack_n <= 1'b1;
        end else if (!rd_pin_n || !wr_pin_n) begin
            cnt_q <= cnt_q + 5'h01;
            transfer_ack_n <= !(cnt_q >= {2'h0, ack_delay});
        end else begin
            cnt_q <= 5'h00;
            transfer_ack_n <= 1'b1;
        end
    end
endmodule

// file: verif/testbench.sv
// self-checking bench for the external bus strobe and request block
`timescale 1ns/1ps
module testbench;
    logic              mclk = 1'b0;
    logic              rst_n = 1'b0;
    ebs_pkg::ebs_cfg_t cfg = '0;
    ebs_pkg::ebs_req_t req = '0;
    logic              low_power = 1'b0;
    logic [2:0]        ack_delay = 3'h0;
    logic              req_ready, done, grant_n, ack_n, read_n_o, read_oe_n, write_n_o, write_oe_n;
    logic              bus_request_n, busy_n_o, busy_oe_n, is_master;
    logic [31:0]       lfsr = 32'h00b3;
    int                n_mismatch = 0;
    int                tests_run = 0;
    wire               rd_pin_n = read_oe_n ? 1'b1 : read_n_o;
    wire               wr_pin_n = write_oe_n ? 1'b1 : write_n_o;

    always #4 mclk = ~mclk;

    ebs_port u_dut (.MCLK(mclk), .RST_N(rst_n), .CFG(cfg), .REQ(req), .REQ_READY(req_ready), .DONE(done),
        .LOW_POWER(low_power), .BUS_GRANT_N(grant_n), .TRANSFER_ACK_N(ack_n), .READ_N_O(read_n_o),
        .READ_OE_N(read_oe_n), .WRITE_N_O(write_n_o), .WRITE_OE_N(write_oe_n), .BUS_REQUEST_N(bus_request_n),
        .BUS_BUSY_N_O(busy_n_o), .BUS_BUSY_OE_N(busy_oe_n), .IS_MASTER(is_master));
    ebs_far_side u_far (.clk(mclk), .rst_n(rst_n), .rd_pin_n(rd_pin_n), .wr_pin_n(wr_pin_n),
        .bus_request_n(bus_request_n), .ack_delay(ack_delay), .bus_grant_n(grant_n), .transfer_ack_n(ack_n));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // counter expires w+1 edges after the take, ack is seen 2+d edges after it (two more synchronised)
    function automatic int exp_cycles(input int w, input int d, input bit async_m, input bit dram);
        int a;
        a = 1 + d + (async_m ? 2 : 0);
        if (w == 0 || dram)
            return w + 3;
        return (w > a ? w : a) + 3;
    endfunction

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic access(input logic [3:0] w, input logic [2:0] d, input logic wr, input logic am, input logic dr);
        int n;
        n = 0;
        cfg.wait_states <= w;
        cfg.ack_sync_select <= am;
        ack_delay <= d;
        req <= '{valid: 1'b1, write: wr, external: 1'b1, dram: dr};
        do @(negedge mclk); while (req_ready !== 1'b1 && ++n < 50);
        @(posedge mclk);
        req.valid <= 1'b0;
        @(negedge mclk);
        check("read strobe", {31'h0, wr}, read_n_o);
        check("write strobe", {31'h0, !wr}, write_n_o);
        check("busy enable", 0, busy_oe_n);
        check("busy level", 0, busy_n_o);
        n = 1;
        while (done !== 1'b1 && n < 60) begin
            @(negedge mclk);
            n++;
        end
        check("cycle length", exp_cycles(w, d, am, dr), n);
        check("strobes at done", 2'h3, {read_n_o, write_n_o});
        @(posedge mclk);
    endtask

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        check("request in reset", 1, bus_request_n);
        check("strobe enables in reset", 2'h3, {read_oe_n, write_oe_n});
        @(posedge mclk);
        rst_n <= 1'b1;
        req <= '{valid: 1'b1, write: 1'b0, external: 1'b0, dram: 1'b0};
        repeat (5) @(posedge mclk);
        @(negedge mclk);
        check("request for internal access", 1, bus_request_n);
        @(posedge mclk);
        req <= '0;
        cfg.request_hold_bit <= 1'b1;
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        check("held request", 0, bus_request_n);
        check("strobe enable as master", 0, read_oe_n);
        @(posedge mclk);
        low_power <= 1'b1;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        check("held request in low power", 0, bus_request_n);
        @(posedge mclk);
        cfg.request_hold_bit <= 1'b0;
        req <= '{valid: 1'b1, write: 1'b1, external: 1'b1, dram: 1'b0};
        repeat (6) @(posedge mclk);
        @(negedge mclk);
        check("request in low power", 1, bus_request_n);
        check("write enable as slave", 1, write_oe_n);
        @(posedge mclk);
        low_power <= 1'b0;
        $display("test arbitration done");
        access(4'h1, 3'h0, 1'b0, 1'b0, 1'b0);
        access(4'h0, 3'h5, 1'b1, 1'b0, 1'b0);
        access(4'h3, 3'h0, 1'b0, 1'b0, 1'b1);
        access(4'hf, 3'h0, 1'b1, 1'b1, 1'b0);
        access(4'h1, 3'h7, 1'b0, 1'b1, 1'b0);
        for (int i = 0; i < 24; i++) begin
            lfsr = lfsr_next(lfsr);
            access(lfsr[3:0], lfsr[6:4], lfsr[7], lfsr[8], lfsr[9] & lfsr[10]);
        end
        $display("test accesses done");
        req <= '{valid: 1'b1, write: 1'b0, external: 1'b1, dram: 1'b0};
        for (int i = 0; i < 50 && read_n_o !== 1'b0; i++)
            @(posedge mclk);
        rst_n <= 1'b0;
        @(negedge mclk);
        check("request in second reset", 1, bus_request_n);
        check("master in second reset", 0, is_master);
        @(posedge mclk);
        rst_n <= 1'b1;
        access(4'h2, 3'h1, 1'b1, 1'b0, 1'b0);
        $display("test second reset done");
        give_verdict();
    end

    initial begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        $display("unexpected watchdog: expected finish, seen timeout");
        give_verdict();
    end
endmodule
